// ---- verilog/asp_pkg.sv ----
// Constants for the asynchronous serial port core.
// How it works
// - Send start, data LSB first, parity, stops.
// - Store error flags alongside each received character.
// - Divisor is 16-bit integer plus 6-bit fraction.
// - Divider makes 16x tick; sixteen ticks per bit.
// - Divisors take effect only on line control write.
// - Two 16-entry FIFOs; receive adds four status bits.
// - Enabled transmitter sends frames until FIFO empties.
// - Busy from non-empty FIFO until last stop sent.
// - Recheck start on eighth tick; reject false starts.
// - Sample data every sixteenth tick, then parity.
// - Stop must be high, else framing error; store.
// - Data read pops twelve bits; write pushes eight.
// - Reset leaves FIFOs one deep until enabled.
// - Flags show FIFO empty/full; status shows overrun.
// - Per-FIFO trigger levels, both half after reset.
// - Raise error, timeout and FIFO level events.
// - Enabled events OR into one interrupt line.
// - Mask gates interrupt; raw status shows all.
// - Writing one to clear drops raw and masked.
// - Loopback routes transmit output into receiver.
// - Transmit and receive enables set at reset, port enable clear; disable finishes character.
package asp_pkg;
	localparam logic [7:0]  ADR_DATA = 8'h00;
	localparam logic [7:0]  ADR_RSR  = 8'h04;
	localparam logic [7:0]  ADR_FLAG = 8'h18;
	localparam logic [7:0]  ADR_IBRD = 8'h24;
	localparam logic [7:0]  ADR_FBRD = 8'h28;
	localparam logic [7:0]  ADR_LCR  = 8'h2c;
	localparam logic [7:0]  ADR_CTL  = 8'h30;
	localparam logic [7:0]  ADR_IFLS = 8'h34;
	localparam logic [7:0]  ADR_IM   = 8'h38;
	localparam logic [7:0]  ADR_RIS  = 8'h3c;
	localparam logic [7:0]  ADR_MIS  = 8'h40;
	localparam logic [7:0]  ADR_ICR  = 8'h44;
	localparam int          LC_BRK   = 0;
	localparam int          LC_PEN   = 1;
	localparam int          LC_EPS   = 2;
	localparam int          LC_STP2  = 3;
	localparam int          LC_FEN   = 4;
	localparam int          LC_WLEN  = 5;
	localparam int          LC_SPS   = 7;
	localparam int          CT_EN    = 0;
	localparam int          CT_LBE   = 7;
	localparam int          CT_TXE   = 8;
	localparam int          CT_RXE   = 9;
	localparam logic [9:0]  CTL_RST  = 10'h300;
	localparam logic [5:0]  IFLS_RST = 6'h12;
	localparam int          IR_RX    = 4;
	localparam int          IR_TX    = 5;
	localparam int          IR_RT    = 6;
	localparam int          IR_FE    = 7;
	localparam int          IR_PE    = 8;
	localparam int          IR_BE    = 9;
	localparam int          IR_OE    = 10;
	localparam int          FR_BUSY  = 3;
	localparam int          FR_RX_FIFO_EMPTY  = 4;
	localparam int          FR_TX_FIFO_FULL  = 5;
	localparam int          FR_RX_FIFO_FULL  = 6;
	localparam int          FR_TX_FIFO_EMPTY  = 7;
	localparam logic [3:0]  OVS_LAST = 4'hf;
	localparam logic [3:0]  START_CK = 4'h7;
	localparam logic [8:0]  RT_TICKS = 9'h1ff;
	localparam logic [22:0] FRAC_ONE = 23'h000040;
endpackage : asp_pkg

// ---- verilog/asp_core.sv ----
// Serial port core: Wishbone registers, baud generator, FIFOs, transmitter, receiver.
`timescale 1ns/100ps
module asp_core #(
	parameter int DEPTH = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rx_i,
	output logic             tx_o,
	output logic             irq_o
);
	localparam int AW = $clog2(DEPTH);

	// The level arithmetic needs a power of two of at least eight entries.
	if (DEPTH < 8 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("asp_core: DEPTH must be a power of two, at least 8");
	end

	typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} asp_tx_t;
	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} asp_rx_t;

	typedef struct packed {
		logic                   ack;
		logic [31:0]            rdat;
		logic [15:0]            ibrd;
		logic [5:0]             fbrd;
		logic [7:0]             lcr;
		logic [29:0]            cfg;
		logic [9:0]             ctl;
		logic [5:0]             ifls;
		logic [10:0]            im;
		logic [10:0]            ris;
		logic [3:0]             rsr;
		logic [22:0]            acc;
		logic                   tick;
		logic [DEPTH-1:0][7:0]  txm;
		logic [AW-1:0]          twp;
		logic [AW-1:0]          trp;
		logic [AW:0]            tcnt;
		logic [DEPTH-1:0][11:0] rxm;
		logic [AW-1:0]          rwp;
		logic [AW-1:0]          rrp;
		logic [AW:0]            rcnt;
		asp_tx_t                ts;
		logic [3:0]             tsub;
		logic                   tbit2;
		logic [2:0]             tbit;
		logic [7:0]             tsh;
		logic                   tpar;
		logic                   tline;
		logic                   txo;
		asp_rx_t                rs;
		logic [3:0]             rsub;
		logic [2:0]             rbit;
		logic [7:0]             rsh;
		logic                   rpe;
		logic                   rprev;
		logic                   rlow;
		logic                   ovp;
		logic [8:0]             rto;
		logic                   irq;
	} asp_state_t;

	asp_state_t st;
	asp_state_t n;

	logic        req;
	logic        wr_lcr;
	logic        rx_line;
	logic [7:0]  lc;
	logic [21:0] div;
	logic [2:0]  last;
	logic [AW:0] eff;
	logic [AW:0] tlvl;
	logic [AW:0] rlvl;
	logic        busy;
	logic [7:0]  rdata;
	logic [31:0] wmerged;
	logic [31:0] wibrd;
	logic [31:0] wctl;

	function automatic logic [AW:0] level(input logic [2:0] sel);
		case (sel)
			3'h0:    level = (AW+1)'(DEPTH / 8);
			3'h1:    level = (AW+1)'(DEPTH / 4);
			3'h2:    level = (AW+1)'(DEPTH / 2);
			3'h3:    level = (AW+1)'(DEPTH * 3 / 4);
			default: level = (AW+1)'(DEPTH * 7 / 8);
		endcase
	endfunction : level

	function automatic logic parity(input logic [7:0] d, input logic [7:0] l);
		logic [7:0] m;
		logic       p;
		m = 8'hff >> (2'h3 - l[asp_pkg::LC_WLEN +: 2]);
		p = ^(d & m);
		if (l[asp_pkg::LC_SPS]) begin
			parity = ~l[asp_pkg::LC_EPS];
		end else begin
			parity = l[asp_pkg::LC_EPS] ? p : ~p;
		end
	endfunction : parity

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		merge = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				merge[i*8 +: 8] = d[i*8 +: 8];
			end
		end
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////
	// Derived views of the registered state.
	// divisor fixed point
	assign div     = st.cfg[21:0];
	assign lc      = st.cfg[29:22];
	assign last    = 3'h4 + {1'b0, lc[asp_pkg::LC_WLEN +: 2]};
	assign eff     = lc[asp_pkg::LC_FEN] ? (AW+1)'(DEPTH) : (AW+1)'(1);
	assign tlvl    = lc[asp_pkg::LC_FEN] ? level(st.ifls[2:0]) : '0;
	assign rlvl    = lc[asp_pkg::LC_FEN] ? level(st.ifls[5:3]) : (AW+1)'(1);
	assign busy    = (st.tcnt != '0) || (st.ts != T_IDLE);
	assign rx_line = st.ctl[asp_pkg::CT_LBE] ? st.txo : rx_i;
	assign rdata   = st.rsh >> (2'h3 - lc[asp_pkg::LC_WLEN +: 2]);
	assign req     = wb_cyc_i && wb_stb_i && !st.ack;
	assign wr_lcr  = req && wb_we_i && (wb_adr_i == asp_pkg::ADR_LCR);
	assign wmerged = merge(32'h0, wb_dat_i, wb_sel_i);
	// Byte-lane merges keep the lanes that a partial write leaves alone.
	assign wibrd   = merge({16'h0, st.ibrd}, wb_dat_i, wb_sel_i);
	assign wctl    = merge({22'h0, st.ctl}, wb_dat_i, wb_sel_i);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic. Clears are applied before sets so that an event in
	// the clearing cycle survives.
	always_comb begin
		n = st;
		n.ack = req;
		n.tick = 1'b0;
		// Bus side: one ack per request, one cycle after it is seen.
		if (req && wb_we_i) begin
			case (wb_adr_i)
				asp_pkg::ADR_DATA: begin
					if (wb_sel_i[0] && st.tcnt != eff) begin
						n.txm[st.twp] = wb_dat_i[7:0];
						n.twp = st.twp + 1'b1;
						n.tcnt = n.tcnt + 1'b1;
					end
				end
				asp_pkg::ADR_RSR:  n.rsr = 4'h0;
				asp_pkg::ADR_IBRD: n.ibrd = wibrd[15:0];
				asp_pkg::ADR_FBRD: n.fbrd = wmerged[5:0];
				asp_pkg::ADR_LCR: begin
					n.lcr = wb_sel_i[0] ? wb_dat_i[7:0] : st.lcr;
					n.cfg = {n.lcr, st.ibrd, st.fbrd};
				end
				asp_pkg::ADR_CTL:  n.ctl = wctl[9:0];
				asp_pkg::ADR_IFLS: n.ifls = wmerged[5:0];
				asp_pkg::ADR_IM:   n.im = wmerged[10:0];
				asp_pkg::ADR_ICR:  n.ris = st.ris & ~wmerged[10:0];
				default: ;
			endcase
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				asp_pkg::ADR_DATA: begin
					n.rdat = (st.rcnt != '0) ? {20'h0, st.rxm[st.rrp]} : 32'h0;
					if (st.rcnt != '0) begin
						n.rrp = st.rrp + 1'b1;
						n.rcnt = n.rcnt - 1'b1;
						n.rto = '0;
					end
				end
				asp_pkg::ADR_RSR:  n.rdat = {28'h0, st.rsr};
				asp_pkg::ADR_FLAG: n.rdat = {24'h0, st.tcnt == '0, st.rcnt == eff,
					st.tcnt == eff, st.rcnt == '0, busy, 3'h0};
				asp_pkg::ADR_IBRD: n.rdat = {16'h0, st.ibrd};
				asp_pkg::ADR_FBRD: n.rdat = {26'h0, st.fbrd};
				asp_pkg::ADR_LCR:  n.rdat = {24'h0, st.lcr};
				asp_pkg::ADR_CTL:  n.rdat = {22'h0, st.ctl};
				asp_pkg::ADR_IFLS: n.rdat = {26'h0, st.ifls};
				asp_pkg::ADR_IM:   n.rdat = {21'h0, st.im};
				asp_pkg::ADR_RIS:  n.rdat = {21'h0, st.ris};
				asp_pkg::ADR_MIS:  n.rdat = {21'h0, st.ris & st.im};
				default:           n.rdat = 32'h0;
			endcase
		end
		// fractional accumulator in 1/64 units makes the 16x tick.
		if (div[21:6] == 16'h0) begin
			n.acc = '0;
		end else if (st.acc + asp_pkg::FRAC_ONE >= {1'b0, div}) begin
			n.acc = st.acc + asp_pkg::FRAC_ONE - {1'b0, div};
			n.tick = 1'b1;
		end else begin
			n.acc = st.acc + asp_pkg::FRAC_ONE;
		end
		// Transmitter. A frame once begun runs to its end whatever the enables.
		n.txo = 1'b1;
		case (st.ts)
			T_IDLE: begin
				n.tline = 1'b1;
				// start when enabled and data waiting
				if (st.ctl[asp_pkg::CT_EN] && st.ctl[asp_pkg::CT_TXE] && st.tcnt != '0) begin
					n.tsh = st.txm[st.trp];
					n.tpar = parity(st.txm[st.trp], lc);
					n.trp = st.trp + 1'b1;
					n.tcnt = n.tcnt - 1'b1;
					n.ts = T_START;
					n.tsub = 4'h0;
					n.tline = 1'b0;
					if (n.tcnt == tlvl) begin
						n.ris[asp_pkg::IR_TX] = 1'b1;
					end
				end
			end
			// start, data LSB first, parity, stops
			T_START: begin
				if (st.tick && st.tsub == asp_pkg::OVS_LAST) begin
					n.ts = T_DATA;
					n.tbit = 3'h0;
					n.tline = st.tsh[0];
				end
			end
			T_DATA: begin
				if (st.tick && st.tsub == asp_pkg::OVS_LAST) begin
					if (st.tbit != last) begin
						n.tbit = st.tbit + 1'b1;
						n.tsh = st.tsh >> 1;
						n.tline = st.tsh[1];
					end else if (lc[asp_pkg::LC_PEN]) begin
						n.ts = T_PAR;
						n.tline = st.tpar;
					end else begin
						n.ts = T_STOP;
						n.tbit2 = 1'b0;
						n.tline = 1'b1;
					end
				end
			end
			T_PAR: begin
				if (st.tick && st.tsub == asp_pkg::OVS_LAST) begin
					n.ts = T_STOP;
					n.tbit2 = 1'b0;
					n.tline = 1'b1;
				end
			end
			T_STOP: begin
				if (st.tick && st.tsub == asp_pkg::OVS_LAST) begin
					if (lc[asp_pkg::LC_STP2] && !st.tbit2) begin
						n.tbit2 = 1'b1;
					end else begin
						n.ts = T_IDLE;
					end
				end
			end
			default: n.ts = T_IDLE;
		endcase
		if (st.ts != T_IDLE && st.tick) begin
			n.tsub = st.tsub + 1'b1;
		end
		// A send-break request forces the line low after the current bit logic.
		n.txo = n.tline & ~lc[asp_pkg::LC_BRK];
		// Receiver.
		n.rprev = rx_line;
		if (st.rs != R_IDLE && st.tick) begin
			n.rsub = st.rsub + 1'b1;
		end
		case (st.rs)
			R_IDLE: begin
				if (st.ctl[asp_pkg::CT_EN] && st.ctl[asp_pkg::CT_RXE] && st.rprev && !rx_line) begin
					n.rs = R_START;
					n.rsub = 4'h0;
				end
			end
			R_START: begin
				if (st.tick && st.rsub == asp_pkg::START_CK) begin
					n.rs = rx_line ? R_IDLE : R_DATA;
					n.rsub = 4'h0;
					n.rbit = 3'h0;
					n.rlow = 1'b1;
					n.rpe = 1'b0;
				end
			end
			R_DATA: begin
				if (st.tick && st.rsub == asp_pkg::OVS_LAST) begin
					n.rsh = {rx_line, st.rsh[7:1]};
					n.rlow = st.rlow & ~rx_line;
					n.rbit = st.rbit + 1'b1;
					if (st.rbit == last) begin
						n.rs = lc[asp_pkg::LC_PEN] ? R_PAR : R_STOP;
					end
				end
			end
			R_PAR: begin
				if (st.tick && st.rsub == asp_pkg::OVS_LAST) begin
					n.rpe = rx_line != parity(rdata, lc);
					n.rlow = st.rlow & ~rx_line;
					n.rs = R_STOP;
				end
			end
			// stop must be high, then store
			R_STOP: begin
				if (st.tick && st.rsub == asp_pkg::OVS_LAST) begin
					n.rs = R_IDLE;
					n.rto = '0;
					n.rlow = st.rlow & ~rx_line;
					n.ris[asp_pkg::IR_FE] = n.ris[asp_pkg::IR_FE] | ~rx_line;
					n.ris[asp_pkg::IR_PE] = n.ris[asp_pkg::IR_PE] | st.rpe;
					n.ris[asp_pkg::IR_BE] = n.ris[asp_pkg::IR_BE] | n.rlow;
					n.rsr = n.rsr | {1'b0, n.rlow, st.rpe, ~rx_line};
					if (n.rcnt == eff) begin
						n.ovp = 1'b1;
						n.rsr[3] = 1'b1;
						n.ris[asp_pkg::IR_OE] = 1'b1;
					end else begin
						n.rxm[st.rwp] = {st.ovp, n.rlow, st.rpe, ~rx_line,
							n.rlow ? 8'h00 : rdata};
						n.rwp = st.rwp + 1'b1;
						n.rcnt = n.rcnt + 1'b1;
						n.ovp = 1'b0;
						if (n.rcnt == rlvl) begin
							n.ris[asp_pkg::IR_RX] = 1'b1;
						end
					end
				end
			end
			default: n.rs = R_IDLE;
		endcase
		// Timeout: 32 idle bit times with data left unread.
		if (st.rcnt == '0 || st.rs != R_IDLE) begin
			n.rto = '0;
		end else if (st.tick && st.rto != asp_pkg::RT_TICKS) begin
			n.rto = st.rto + 1'b1;
		end else if (st.tick) begin
			n.ris[asp_pkg::IR_RT] = 1'b1;
			n.rto = '0;
		end
		n.irq = |(n.ris & n.im);
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.ctl <= asp_pkg::CTL_RST;
			st.ifls <= asp_pkg::IFLS_RST;
			st.ts <= T_IDLE;
			st.rs <= R_IDLE;
			st.tline <= 1'b1;
			st.txo <= 1'b1;
			st.rprev <= 1'b1;
		end else begin
			st <= n;
		end
	end

	assign wb_dat_o = st.rdat;
	assign wb_ack_o = st.ack;
	assign tx_o     = st.txo;
	assign irq_o    = st.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_tx_start_low: assert property (st.ts == T_IDLE && n.ts == T_START |=> tx_o == 1'b0)
		else $error("start bit not low");
	chk_cfg_hold: assert property (!wr_lcr |=> $stable(st.cfg))
		else $error("divisor changed without line control write");
	chk_tick_rate: assert property (st.tick && div >= 22'h80 |=> !st.tick)
		else $error("tick too fast for divisor");
	// short divisors tick at least every other clock.
	chk_tick_gap: assert property (st.tick && div < 22'h80 && div[21:6] != 16'h0
		|=> ##[0:1] st.tick)
		else $error("tick gap too long for divisor");
	chk_busy_shift: assert property (st.ts != T_IDLE |-> busy)
		else $error("busy low while shifting");
	chk_false_start: assert property (st.rs == R_START && st.tick
		&& st.rsub == asp_pkg::START_CK && rx_line |=> st.rs == R_IDLE)
		else $error("false start not rejected");
	chk_depth_one: assert property (!lc[asp_pkg::LC_FEN] |-> st.tcnt <= 1 && st.rcnt <= 1)
		else $error("FIFO deeper than one while disabled");
	chk_irq_or: assert property (irq_o == |(st.ris & st.im))
		else $error("interrupt line mismatch");
	// A disabled port may only leave a frame at the end of its stop bit.
	chk_finish_char: assert property (st.ts != T_IDLE && !st.ctl[asp_pkg::CT_EN]
		&& !(st.ts == T_STOP && st.tick && st.tsub == asp_pkg::OVS_LAST) |=> st.ts != T_IDLE)
		else $error("character cut by disable");

	cov_tx_frame: cover property (st.ts == T_STOP ##1 st.ts == T_IDLE);
	cov_rx_push:  cover property (st.rs == R_STOP ##1 st.rcnt != '0);
	cov_overrun:  cover property (st.rsr[3]);
	cov_false:    cover property (st.rs == R_START ##1 st.rs == R_IDLE);
endmodule : asp_core

// ---- verification/asp_remote.sv ----
// Far-side serial station: sends frames to the core and collects its output.
`timescale 1ns/100ps
module asp_remote (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	int         bit_clks = 16; // Clocks per bit, set by the bench.
	bit         par_en   = 1'b0; // Frames carry even parity when set.
	int         low_clks = 0; // Length of the latest low stretch.
	realtime    t0;
	logic [7:0] d;
	logic       p;
	logic [9:0] got_q[$]; // Collected {stop, parity, data}.

	initial line_o = 1'b1;

	////////////////////////////////////////////////////////////////
	// mid-bit sampling, LSB first.
	always begin
		@(negedge line_i);
		p = 1'b0;
		repeat (bit_clks / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clks) @(posedge clk_i);
			d[i] = line_i;
		end
		if (par_en) begin
			repeat (bit_clks) @(posedge clk_i);
			p = line_i;
		end
		repeat (bit_clks) @(posedge clk_i);
		got_q.push_back({line_i, p, d});
	end

	// bit time seen. A low stretch spans whole bits, so 0x55 shows one bit time.
	always begin
		@(negedge line_i);
		// Real time keeps the half-nanosecond clock edges from rounding apart.
		t0 = $realtime;
		@(posedge line_i);
		low_clks = int'(($realtime - t0) / 5.0);
	end

	////////////////////////////////////////////////////////////////
	// short low pulse. It ends well before the start recheck.
	task automatic glitch();
		line_o <= 1'b0;
		repeat (bit_clks / 4) @(posedge clk_i);
		line_o <= 1'b1;
		repeat (bit_clks * 2) @(posedge clk_i);
	endtask : glitch

	// frame sending. Data zero with a bad stop is a whole low frame.
	task automatic send(input logic [7:0] v, input bit bad_p, input bit bad_s);
		logic [10:0] f;
		f = {~bad_s, ^v ^ bad_p, v, 1'b0};
		for (int i = 0; i < 11; i++) begin
			if (i != 9 || par_en) begin
				line_o <= f[i];
				repeat (bit_clks) @(posedge clk_i);
			end
		end
		line_o <= 1'b1;
		repeat (bit_clks) @(posedge clk_i);
	endtask : send
endmodule : asp_remote

// ---- verification/tb_async_serial_port_core.sv ----
// Self-checking bench for the serial port core and its register bus.
`timescale 1ns/100ps
module tb_async_serial_port_core;
	logic        clk_i           = 1'b0;
	logic        rst_i           = 1'b1;
	logic        cyc             = 1'b0; // Cycle and strobe move together.
	logic        we              = 1'b0;
	logic [7:0]  adr             = 8'h00;
	logic [31:0] wdat            = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic        ack;
	logic        tx;
	logic        rx;
	logic        irq;
	int          failures        = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	logic [31:0] rx_exp[4]       = '{32'h3c, 32'h281, 32'h15a, 32'h500};

	////////////////////////////////////////////////////////////////
	// Design and far-side station.
	asp_core #(
		.DEPTH(16)
	) u_dut (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.wb_cyc_i(cyc),
		.wb_stb_i(cyc),
		.wb_we_i (we),
		.wb_adr_i(adr),
		.wb_sel_i(4'hf),
		.wb_dat_i(wdat),
		.wb_dat_o(rdat),
		.wb_ack_o(ack),
		.rx_i    (rx),
		.tx_o    (tx),
		.irq_o   (irq)
	);
	asp_remote u_far (
		.clk_i (clk_i),
		.line_i(tx),
		.line_o(rx)
	);

	// Clock at 200 MHz and a watchdog so a hang still reaches the verdict.
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failures++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////
	// Comparison of a seen value with an expected one.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s: %h not %h", $time, what, seen, exp);
		end
	endtask : check

	// The request stands until ack is seen at a rising edge; read data is taken there.
	// Only the watchdog ends a wait for the answer.
	task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		we  <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(a, 32'h0, 1'b0);
		check(rd, exp, what);
	endtask : rchk

	// Polls a flag bit under a bounded count of reads.
	task automatic wait_flag(input int b, input logic v);
		int n;
		n = 0;
		do begin
			bus(asp_pkg::ADR_FLAG, 32'h0, 1'b0);
			n++;
		end while (rd[b] !== v && n < 2000);
		check({31'h0, rd[b]}, {31'h0, v}, "flag wait");
	endtask : wait_flag

	// disable, divisors, line control, then control.
	task automatic setup(input logic [31:0] ib, input logic [31:0] lcr, input logic [31:0] ctl);
		bus(asp_pkg::ADR_CTL, 32'h0);
		bus(asp_pkg::ADR_IBRD, ib);
		bus(asp_pkg::ADR_FBRD, 32'h0);
		bus(asp_pkg::ADR_LCR, lcr);
		bus(asp_pkg::ADR_CTL, ctl);
	endtask : setup

	task automatic conclude();
		$display("checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////
	// Main sequence of tests.
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rchk(asp_pkg::ADR_CTL, 32'h300, "ctl rst");
		rchk(asp_pkg::ADR_IFLS, 32'h12, "lvl rst");
		rchk(asp_pkg::ADR_FLAG, 32'h90, "flag rst");
		rchk(8'h48, 32'h0, "unmapped");
		check({31'h0, tx}, 32'h1, "idle");
		$display("test reset done");
		// Holding register is one deep while the port is off; busy shows anyway.
		setup(32'h1, 32'h60, 32'h300);
		bus(asp_pkg::ADR_DATA, 32'h55);
		bus(asp_pkg::ADR_DATA, 32'haa);
		rchk(asp_pkg::ADR_FLAG, 32'h38, "off full");
		bus(asp_pkg::ADR_CTL, 32'h301);
		wait_flag(asp_pkg::FR_BUSY, 1'b0);
		check(u_far.got_q.size(), 32'h1, "frames");
		check({22'h0, u_far.got_q[0]}, 32'h255, "frame");
		check(u_far.low_clks, 32'h10, "bit time");
		$display("test holding done");
		// Sixteen entries fill the transmit FIFO; the seventeenth is dropped.
		u_far.got_q.delete();
		setup(32'h1, 32'h70, 32'h300);
		for (int i = 0; i < 17; i++) begin
			bus(asp_pkg::ADR_DATA, 32'h30 + i);
		end
		rchk(asp_pkg::ADR_FLAG, 32'h38, "fifo full");
		bus(asp_pkg::ADR_CTL, 32'h301);
		wait_flag(asp_pkg::FR_BUSY, 1'b0);
		check(u_far.got_q.size(), 32'h10, "count");
		for (int i = 0; i < 16; i++) begin
			check({22'h0, u_far.got_q[i]}, 32'h230 + i, "order");
		end
		$display("test fifo done");
		// A frame under way finishes after the port is switched off.
		bus(asp_pkg::ADR_DATA, 32'h4b);
		bus(asp_pkg::ADR_CTL, 32'h300);
		rchk(asp_pkg::ADR_FLAG, 32'h98, "off busy");
		wait_flag(asp_pkg::FR_BUSY, 1'b0);
		check(u_far.got_q.size(), 32'h11, "cut count");
		check({22'h0, u_far.got_q[16]}, 32'h24b, "cut frame");
		$display("test disable done");
		// A false start, then a good frame and frames with parity, framing and break faults.
		u_far.par_en = 1'b1;
		setup(32'h1, 32'h76, 32'h301);
		u_far.glitch();
		u_far.send(8'h3c, 1'b0, 1'b0);
		u_far.send(8'h81, 1'b1, 1'b0);
		u_far.send(8'h5a, 1'b0, 1'b1);
		u_far.send(8'h00, 1'b0, 1'b1);
		bus(asp_pkg::ADR_RIS, 32'h0, 1'b0);
		check(rd & 32'h390, 32'h380, "events");
		for (int i = 0; i < 4; i++) begin
			rchk(asp_pkg::ADR_DATA, rx_exp[i], "rx");
		end
		bus(asp_pkg::ADR_ICR, 32'h7f0);
		bus(asp_pkg::ADR_RIS, 32'h0, 1'b0);
		check(rd & 32'h780, 32'h0, "cleared");
		$display("test receive done");
		// A second character into a full holding register is lost.
		u_far.par_en = 1'b0;
		setup(32'h1, 32'h60, 32'h301);
		bus(asp_pkg::ADR_RSR, 32'h0);
		u_far.send(8'h11, 1'b0, 1'b0);
		u_far.send(8'h22, 1'b0, 1'b0);
		rchk(asp_pkg::ADR_RSR, 32'h8, "overrun");
		rchk(asp_pkg::ADR_DATA, 32'h11, "kept");
		check({31'h0, irq}, 32'h0, "masked");
		bus(asp_pkg::ADR_IM, 32'h400);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq}, 32'h1, "irq");
		rchk(asp_pkg::ADR_MIS, 32'h400, "mis");
		bus(asp_pkg::ADR_ICR, 32'h7f0);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq}, 32'h0, "irq clr");
		u_far.send(8'h33, 1'b0, 1'b0);
		// Left unread, the character raises the level and then the timeout event.
		repeat (600) @(posedge clk_i);
		bus(asp_pkg::ADR_RIS, 32'h0, 1'b0);
		check(rd & 32'h50, 32'h50, "level and timeout");
		rchk(asp_pkg::ADR_DATA, 32'h833, "oe tag");
		bus(asp_pkg::ADR_IM, 32'h0);
		$display("test overrun done");
		// Loopback: the receiver hears the transmitter, not the pin.
		bus(asp_pkg::ADR_CTL, 32'h381);
		bus(asp_pkg::ADR_DATA, 32'h96);
		wait_flag(asp_pkg::FR_RX_FIFO_EMPTY, 1'b0);
		rchk(asp_pkg::ADR_DATA, 32'h96, "loop");
		wait_flag(asp_pkg::FR_BUSY, 1'b0);
		$display("test loopback done");
		// New divisors wait for a line control write.
		bus(asp_pkg::ADR_CTL, 32'h300);
		bus(asp_pkg::ADR_FBRD, 32'h20);
		bus(asp_pkg::ADR_CTL, 32'h301);
		bus(asp_pkg::ADR_DATA, 32'h55);
		wait_flag(asp_pkg::FR_BUSY, 1'b0);
		check(u_far.low_clks, 32'h10, "old div");
		bus(asp_pkg::ADR_CTL, 32'h300);
		bus(asp_pkg::ADR_LCR, 32'h60);
		bus(asp_pkg::ADR_CTL, 32'h301);
		u_far.bit_clks = 24;
		bus(asp_pkg::ADR_DATA, 32'h55);
		wait_flag(asp_pkg::FR_BUSY, 1'b0);
		check(u_far.low_clks, 32'h18, "frac div");
		$display("test divisor done");
		conclude();
	end
endmodule : tb_async_serial_port_core
